// ---- rtl/fpc_pkg.sv ----
// package: constants, states and carriers of the flash program controller
package fpc_pkg;

    // register addresses in the special-function-register space
    localparam logic [7:0] ADDR_SEC_HI = 8'hFA;
    localparam logic [7:0] ADDR_SEC_MID = 8'hFB;
    localparam logic [7:0] ADDR_SEC_LO = 8'hFC;
    localparam logic [7:0] ADDR_KEY = 8'hFD;
    localparam logic [7:0] ADDR_CTRL = 8'hFE;

    // reset values and field layout
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] SEC_HI_RESET = 4'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam int unsigned BUSY_BIT = 7;
    localparam logic [7:0] KEY_VALID = 8'hA5;
    localparam logic [7:0] ERASED_BYTE = 8'h00;

    // mode-control codes
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_BUF_CLR = 3'h1;
    localparam logic [2:0] MODE_ERASE = 3'h2;
    localparam logic [2:0] MODE_WRITE = 3'h3;
    localparam logic [2:0] MODE_LOCK = 3'h4;

    // array geometry
    localparam int unsigned FLASH_BYTES = 32768;
    localparam int unsigned SECTOR_BYTES = 64;
    localparam int unsigned SECTORS = 512;
    localparam logic [5:0] LAST_IDX = 6'h3F;
    localparam logic [9:0] PBUF_BASE_HI = 10'h200;

    // protection area bounds
    localparam logic [14:0] PROT_BASE = 15'h0100;
    localparam logic [14:0] PROT_TOP_00 = 15'h0FFF;
    localparam logic [14:0] PROT_TOP_01 = 15'h07FF;
    localparam logic [14:0] PROT_TOP_10 = 15'h03FF;
    localparam logic [14:0] PROT_TOP_11 = 15'h01FF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } fpc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } fpc_sfr_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic [7:0]  wdata;
    } fpc_xd_req_t;

    typedef struct packed {
        logic protect_enable_n;
        logic protect_size_sel_hi;
        logic protect_size_sel_lo;
        logic user_mode;
    } fpc_cfg_t;

endpackage

// ---- rtl/fpc_protect_chk.sv ----
// protection area decoder for one byte address of the array
`timescale 1ns/1ns
`default_nettype none

module fpc_protect_chk (
    input  wire logic [14:0]     byte_addr,
    input  wire fpc_pkg::fpc_cfg_t cfg,
    output var logic             hit
);

    logic [14:0] top;

    always_comb begin
        case ({cfg.protect_size_sel_hi, cfg.protect_size_sel_lo})
            2'b00:   top = fpc_pkg::PROT_TOP_00;
            2'b01:   top = fpc_pkg::PROT_TOP_01;
            2'b10:   top = fpc_pkg::PROT_TOP_10;
            default: top = fpc_pkg::PROT_TOP_11;
        endcase
    end

    // only self-programming is fenced; debugger and serial modes are not
    always_comb begin
        hit = cfg.user_mode && !cfg.protect_enable_n
              && (byte_addr >= fpc_pkg::PROT_BASE) && (byte_addr <= top);
    end

endmodule // fpc_protect_chk

`default_nettype wire

// ---- rtl/fpc_flash_ctrl.sv ----
// flash program controller: registers, page buffer, array, sequencer
`timescale 1ns/1ns
`default_nettype none

module fpc_flash_ctrl (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  prog_mode,
    input  wire fpc_pkg::fpc_sfr_req_t sfr_req,
    input  wire fpc_pkg::fpc_xd_req_t  xd_req,
    input  wire logic                  pm_rd,
    input  wire logic [14:0]           pm_addr,
    input  wire fpc_pkg::fpc_cfg_t     cfg,
    input  wire logic                  global_irq_enable,
    output logic [7:0]                 sfr_rdata_q,
    output logic [7:0]                 pm_rdata_q,
    output logic                       cpu_hold_q,
    output logic                       irq_en_q
);

    ////////////////////////////////////////////////////////////////////////
    // storage and state

    fpc_pkg::fpc_state_t state_q;
    fpc_pkg::fpc_state_t state_d;
    logic [3:0]          sec_hi_q;
    logic [7:0]          sec_mid_q;
    logic [7:0]          sec_lo_q;
    logic [7:0]          key_q;
    logic [2:0]          mode_q;
    logic                busy_q;
    logic                busy_d;
    logic [5:0]          idx_q;
    logic [7:0]          pbuf_q [fpc_pkg::SECTOR_BYTES];
    logic [7:0]          flash_q [fpc_pkg::FLASH_BYTES];
    logic [fpc_pkg::SECTORS-1:0] lock_q;

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic        reg_wr;
    logic        ctrl_wr;
    logic [2:0]  wcode;
    logic        keyed;
    logic        key_ok;
    logic        sec_ok;
    logic        start;
    logic [8:0]  sec_idx;
    logic [14:0] cur_addr;
    logic        prot_hit;
    logic        locked;
    logic        running;
    logic        arr_we;
    logic        buf_clr;
    logic        xd_hit;
    logic [7:0]  cur_byte;

    // cpu is stalled while busy, so writes then are dropped outright
    assign reg_wr = sfr_req.wr && prog_mode
                    && (state_q == fpc_pkg::ST_IDLE);
    assign ctrl_wr = reg_wr && (sfr_req.addr == fpc_pkg::ADDR_CTRL);
    assign wcode = sfr_req.wdata[2:0];
    assign keyed = (wcode == fpc_pkg::MODE_ERASE)
                   || (wcode == fpc_pkg::MODE_WRITE)
                   || (wcode == fpc_pkg::MODE_LOCK);
    assign key_ok = (key_q == fpc_pkg::KEY_VALID);
    // a sector address beyond the array selects nothing
    assign sec_ok = (sec_hi_q == fpc_pkg::SEC_HI_RESET) && !sec_mid_q[7];
    assign start = ctrl_wr
                   && ((wcode == fpc_pkg::MODE_BUF_CLR)
                       || (keyed && key_ok && sec_ok));
    assign sec_idx = {sec_mid_q[6:0], sec_lo_q[7:6]};
    assign cur_addr = {sec_idx, idx_q};
    assign running = (state_q == fpc_pkg::ST_RUN);
    assign locked = lock_q[sec_idx];
    assign cur_byte = flash_q[cur_addr];
    assign buf_clr = running && (mode_q == fpc_pkg::MODE_BUF_CLR)
                     && (idx_q == 6'h00);
    assign xd_hit = xd_req.wr && (xd_req.addr[15:6] == fpc_pkg::PBUF_BASE_HI);

    fpc_protect_chk u_protect (
        .byte_addr (cur_addr),
        .cfg       (cfg),
        .hit       (prot_hit)
    );

    // a hard-locked sector refuses erase and write for good
    assign arr_we = running && !prot_hit && !locked
                    && ((mode_q == fpc_pkg::MODE_ERASE)
                        || (mode_q == fpc_pkg::MODE_WRITE));

    ////////////////////////////////////////////////////////////////////////
    // sequencer: one byte per cycle over the whole sector

    always_comb begin
        case (state_q)
            fpc_pkg::ST_IDLE: begin
                state_d = start ? fpc_pkg::ST_RUN : fpc_pkg::ST_IDLE;
            end
            fpc_pkg::ST_RUN: begin
                state_d = (idx_q == fpc_pkg::LAST_IDX) ? fpc_pkg::ST_DONE
                                                       : fpc_pkg::ST_RUN;
            end
            fpc_pkg::ST_DONE: begin
                state_d = fpc_pkg::ST_IDLE;
            end
            default: begin
                state_d = fpc_pkg::ST_IDLE;
            end
        endcase
    end

    assign busy_d = (state_d != fpc_pkg::ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= fpc_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            idx_q <= 6'h00;
        end else if (running) begin
            idx_q <= idx_q + 6'h01;
        end else begin
            idx_q <= 6'h00;
        end
    end

    // stall, interrupt mask and busy flag share one next value
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy_q     <= 1'b0;
            cpu_hold_q <= 1'b0;
            irq_en_q   <= 1'b0;
        end else begin
            busy_q     <= busy_d;
            cpu_hold_q <= busy_d;
            irq_en_q   <= global_irq_enable && !busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sector address, key and mode registers

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sec_hi_q  <= fpc_pkg::SEC_HI_RESET;
            sec_mid_q <= fpc_pkg::REG_RESET;
            sec_lo_q  <= fpc_pkg::REG_RESET;
        end else if (reg_wr) begin
            if (sfr_req.addr == fpc_pkg::ADDR_SEC_HI) begin
                sec_hi_q <= sfr_req.wdata[3:0];
            end
            if (sfr_req.addr == fpc_pkg::ADDR_SEC_MID) begin
                sec_mid_q <= sfr_req.wdata;
            end
            if (sfr_req.addr == fpc_pkg::ADDR_SEC_LO) begin
                sec_lo_q <= sfr_req.wdata;
            end
        end
    end

    // a refused keyed command also spends the key
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            key_q <= fpc_pkg::REG_RESET;
        end else if (state_q == fpc_pkg::ST_DONE) begin
            key_q <= fpc_pkg::REG_RESET;
        end else if (ctrl_wr && keyed && !start) begin
            key_q <= fpc_pkg::REG_RESET;
        end else if (reg_wr && (sfr_req.addr == fpc_pkg::ADDR_KEY)) begin
            key_q <= sfr_req.wdata;
        end
    end

    // bit 7 written as one is dropped; only the code field is stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_q <= fpc_pkg::MODE_RESET;
        end else if (state_q == fpc_pkg::ST_DONE) begin
            mode_q <= fpc_pkg::MODE_NONE;
        end else if (ctrl_wr) begin
            mode_q <= start ? wcode : fpc_pkg::MODE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page buffer, one entry per generate step

    for (genvar i = 0; i < fpc_pkg::SECTOR_BYTES; i++) begin : g_pbuf
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                pbuf_q[i] <= fpc_pkg::REG_RESET;
            end else if (buf_clr) begin
                pbuf_q[i] <= fpc_pkg::REG_RESET;
            end else if (xd_hit && (xd_req.addr[5:0] == 6'(i))) begin
                pbuf_q[i] <= xd_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array, lock bits and read ports

    // array content is non-volatile by nature, so it takes no reset
    always_ff @(posedge clk_sys) begin
        if (arr_we) begin
            flash_q[cur_addr] <= (mode_q == fpc_pkg::MODE_WRITE)
                                 ? pbuf_q[idx_q]
                                 : fpc_pkg::ERASED_BYTE;
        end
    end

    // lock bits reset here only to give simulation a known state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lock_q <= '0;
        end else if (running && (mode_q == fpc_pkg::MODE_LOCK)
                     && (idx_q == 6'h00)) begin
            lock_q[sec_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pm_rdata_q <= fpc_pkg::REG_RESET;
        end else if (pm_rd) begin
            pm_rdata_q <= flash_q[pm_addr];
        end
    end

    // reads stay open while busy so a debugger can poll the busy flag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sfr_rdata_q <= fpc_pkg::REG_RESET;
        end else if (sfr_req.rd && prog_mode) begin
            case (sfr_req.addr)
                fpc_pkg::ADDR_SEC_HI:  sfr_rdata_q <= {4'h0, sec_hi_q};
                fpc_pkg::ADDR_SEC_MID: sfr_rdata_q <= sec_mid_q;
                fpc_pkg::ADDR_SEC_LO:  sfr_rdata_q <= sec_lo_q;
                fpc_pkg::ADDR_KEY:     sfr_rdata_q <= key_q;
                fpc_pkg::ADDR_CTRL: begin
                    sfr_rdata_q <= {busy_q, 4'h0, mode_q};
                end
                default:               sfr_rdata_q <= fpc_pkg::REG_RESET;
            endcase
        end else begin
            sfr_rdata_q <= fpc_pkg::REG_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    chk_sfr_gate:
    assert property (sfr_req.rd && !prog_mode |=> sfr_rdata_q == 8'h00)
        else $error("register read answered outside programming mode");

    chk_key_refused:
    assert property (ctrl_wr && keyed && !key_ok
                     |=> state_q == fpc_pkg::ST_IDLE && key_q == 8'h00
                         && mode_q == fpc_pkg::MODE_NONE)
        else $error("keyed command ran without valid key");

    chk_key_clear:
    assert property (state_q == fpc_pkg::ST_DONE
                     |=> key_q == 8'h00 && mode_q == fpc_pkg::MODE_NONE
                         && !busy_q)
        else $error("key or mode not cleared after operation");

    chk_clr_start:
    assert property (ctrl_wr && wcode == fpc_pkg::MODE_BUF_CLR
                     |=> running ##1 pbuf_q[0] == 8'h00
                         && pbuf_q[63] == 8'h00)
        else $error("buffer clear did not start or clear");

    chk_keyed_start:
    assert property (ctrl_wr && keyed && key_ok && sec_ok
                     |=> running && mode_q == $past(wcode))
        else $error("valid keyed command did not start");

    chk_bad_code:
    assert property (ctrl_wr && !keyed && wcode != fpc_pkg::MODE_BUF_CLR
                     |=> state_q == fpc_pkg::ST_IDLE && !busy_q)
        else $error("undefined code started an operation");

    chk_hold_mask:
    assert property (state_q != fpc_pkg::ST_IDLE
                     |-> busy_q && cpu_hold_q && !irq_en_q)
        else $error("cpu not stalled or interrupts open while busy");

    chk_busy_read:
    assert property (sfr_req.rd && prog_mode
                     && sfr_req.addr == fpc_pkg::ADDR_CTRL
                     |=> sfr_rdata_q[fpc_pkg::BUSY_BIT] == $past(busy_q))
        else $error("busy bit does not show operation state");

    chk_protect_keep:
    assert property (running && (prot_hit || locked)
                     |=> flash_q[$past(cur_addr)] == $past(cur_byte))
        else $error("protected or locked byte was altered");

    chk_busy_span:
    assert property ($rose(busy_q) |-> ##64 busy_q ##1 !busy_q
                     && !cpu_hold_q)
        else $error("busy span is not 65 cycles");

    cov_erase: cover property (running && mode_q == fpc_pkg::MODE_ERASE);
    cov_write: cover property (arr_we && mode_q == fpc_pkg::MODE_WRITE);
    cov_lock: cover property (running && mode_q == fpc_pkg::MODE_LOCK);
    cov_guard: cover property (running && prot_hit);

endmodule // fpc_flash_ctrl

`default_nettype wire

// ---- test/fpc_cpu_model.sv ----
// cpu core model: register, data-space and code-read requests
`timescale 1ns/1ns
`default_nettype none

module fpc_cpu_model (
    input  wire logic                 clk_sys,
    input  wire logic                 cpu_hold_q,
    input  wire logic [7:0]           sfr_rdata_q,
    input  wire logic [7:0]           pm_rdata_q,
    output var fpc_pkg::fpc_sfr_req_t sfr_req,
    output var fpc_pkg::fpc_xd_req_t  xd_req,
    output var logic                  pm_rd,
    output var logic [14:0]           pm_addr
);
    initial begin
        sfr_req = '0;
        xd_req = '0;
        pm_rd = 1'b0;
        pm_addr = 15'h0000;
    end
    // a stalled core executes nothing, so it issues nothing
    task automatic idle();
        while (cpu_hold_q !== 1'b0) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        idle();
        sfr_req <= {a, 1'b1, 1'b0, d};
        @(negedge clk_sys);
        sfr_req.wr <= 1'b0;
    endtask
    // dbg lets a debugger peek while the core is held
    task automatic rd(input logic [7:0] a, input logic dbg,
                      output logic [7:0] d);
        @(negedge clk_sys);
        if (!dbg) idle();
        sfr_req <= {a, 1'b0, 1'b1, 8'h00};
        @(negedge clk_sys);
        sfr_req.rd <= 1'b0;
        d = sfr_rdata_q;
    endtask
    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        idle();
        xd_req <= {a, 1'b1, d};
        @(negedge clk_sys);
        xd_req.wr <= 1'b0;
    endtask
    task automatic pr(input logic [14:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        idle();
        pm_addr <= a;
        pm_rd <= 1'b1;
        @(negedge clk_sys);
        pm_rd <= 1'b0;
        d = pm_rdata_q;
    endtask
    // three dummy instructions after a mode write
    task automatic nop3();
        idle();
        repeat (3) @(negedge clk_sys);
    endtask
endmodule // fpc_cpu_model

`default_nettype wire

// ---- test/fpc_flash_ctrl_tb.sv ----
// self-checking bench of the flash program controller
`timescale 1ns/1ns
`default_nettype none

module fpc_flash_ctrl_tb;
    logic                  clk_sys = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  prog_mode = 1'b1;
    logic                  global_irq_enable = 1'b1;
    fpc_pkg::fpc_cfg_t     cfg = '0;
    fpc_pkg::fpc_sfr_req_t sfr_req;
    fpc_pkg::fpc_xd_req_t  xd_req;
    logic                  pm_rd;
    logic [14:0]           pm_addr;
    logic [7:0]            sfr_rdata_q;
    logic [7:0]            pm_rdata_q;
    logic                  cpu_hold_q;
    logic                  irq_en_q;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    int                    cyc = 0;
    logic [7:0]            pat [64];
    logic [7:0]            d;
    logic [7:0]            r;
    logic [8:0]            s;
    logic [14:0]           top;
    logic                  far = 1'b0;

    fpc_flash_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .prog_mode(prog_mode), .sfr_req(sfr_req), .xd_req(xd_req),
        .pm_rd(pm_rd), .pm_addr(pm_addr), .cfg(cfg),
        .global_irq_enable(global_irq_enable), .sfr_rdata_q(sfr_rdata_q),
        .pm_rdata_q(pm_rdata_q), .cpu_hold_q(cpu_hold_q),
        .irq_en_q(irq_en_q));
    fpc_cpu_model i_cpu (.clk_sys(clk_sys), .cpu_hold_q(cpu_hold_q),
        .sfr_rdata_q(sfr_rdata_q), .pm_rdata_q(pm_rdata_q),
        .sfr_req(sfr_req), .xd_req(xd_req), .pm_rd(pm_rd),
        .pm_addr(pm_addr));

    initial forever #25 clk_sys = ~clk_sys;

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // the whole run needs well under 10000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fill();
        for (int i = 0; i < 64; i++) begin
            pat[i] = 8'($urandom_range(255, 1));
            i_cpu.xw(16'h8000 + 16'(i), pat[i]);
        end
    endtask
    task automatic setsec(input logic [8:0] sn);
        i_cpu.wr(fpc_pkg::ADDR_SEC_HI, 8'h00);
        i_cpu.wr(fpc_pkg::ADDR_SEC_MID, {1'b0, sn[8:2]});
        i_cpu.wr(fpc_pkg::ADDR_SEC_LO, {sn[1:0], 6'h00});
    endtask
    // z set: the sector must read back erased
    task automatic cmp(input logic [8:0] sn, input logic z);
        for (int i = 0; i < 64; i++) begin
            i_cpu.pr({sn, 6'(i)}, d);
            chk(d, z ? 8'h00 : pat[i]);
        end
    endtask
    // far set: the sector address lies beyond the array
    function automatic logic starts(input logic [2:0] c,
                                    input logic [7:0] k);
        return c == fpc_pkg::MODE_BUF_CLR
               || (c inside {[fpc_pkg::MODE_ERASE:fpc_pkg::MODE_LOCK]}
                   && k == fpc_pkg::KEY_VALID && !far);
    endfunction
    task automatic op(input logic [2:0] c, input logic [7:0] k);
        logic [7:0] n;
        logic go;
        n = 8'h00;
        go = starts(c, k);
        global_irq_enable = 1'($urandom);
        i_cpu.wr(fpc_pkg::ADDR_KEY, k);
        // upper bits set on purpose; they must be ignored
        i_cpu.wr(fpc_pkg::ADDR_CTRL, {5'h1F, c});
        for (int i = 0; i < 80; i++) begin
            if (cpu_hold_q === 1'b1) n++;
            if (i == 9 && go) chk({7'h00, irq_en_q}, 8'h00);
            if (i == 20 && go) begin
                i_cpu.rd(fpc_pkg::ADDR_CTRL, 1'b1, d);
                chk(d, {5'h10, c});
                n = n + 8'h02;
            end
            @(negedge clk_sys);
        end
        chk(n, go ? 8'h41 : 8'h00);
        i_cpu.nop3();
        chk({7'h00, irq_en_q}, {7'h00, global_irq_enable});
        i_cpu.rd(fpc_pkg::ADDR_CTRL, 1'b0, d);
        chk(d, 8'h00);
        i_cpu.rd(fpc_pkg::ADDR_KEY, 1'b0, d);
        chk(d, (c inside {[3'h1:3'h4]}) ? 8'h00 : k);
    endtask

    initial begin
        void'($urandom(32'hA7B48CD3));
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        // five registers then one unmapped place, all zero
        for (int a = 8'hFA; a <= 8'hFF; a++) begin
            i_cpu.rd(8'(a), 1'b0, d);
            chk(d, 8'h00);
        end
        $display("test reset values done");
        prog_mode = 1'b0;
        i_cpu.wr(fpc_pkg::ADDR_KEY, fpc_pkg::KEY_VALID);
        i_cpu.rd(fpc_pkg::ADDR_KEY, 1'b0, d);
        chk(d, 8'h00);
        prog_mode = 1'b1;
        i_cpu.rd(fpc_pkg::ADDR_KEY, 1'b0, d);
        chk(d, 8'h00);
        for (int a = 8'hFA; a <= 8'hFD; a++) begin
            r = 8'($urandom);
            i_cpu.wr(8'(a), r);
            i_cpu.rd(8'(a), 1'b0, d);
            chk(d, a == 8'hFA ? {4'h0, r[3:0]} : r);
        end
        $display("test register access done");
        s = 9'(100 + $urandom_range(399, 0));
        fill();
        setsec(s);
        op(fpc_pkg::MODE_WRITE, fpc_pkg::KEY_VALID);
        cmp(s, 1'b0);
        r = 8'($urandom);
        if (r == fpc_pkg::KEY_VALID) r = 8'h5A;
        op(fpc_pkg::MODE_ERASE, r);
        cmp(s, 1'b0);
        // valid key but an address past the array: refused
        far = 1'b1;
        i_cpu.wr(fpc_pkg::ADDR_SEC_HI, 8'h01);
        op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
        far = 1'b0;
        setsec(s);
        for (int j = 0; j < 4; j++)
            op(3'(j == 0 ? 0 : j + 4), fpc_pkg::KEY_VALID);
        cmp(s, 1'b0);
        op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
        cmp(s, 1'b1);
        $display("test write and erase done");
        fill();
        op(fpc_pkg::MODE_BUF_CLR, 8'($urandom));
        setsec(s + 9'h001);
        op(fpc_pkg::MODE_WRITE, fpc_pkg::KEY_VALID);
        cmp(s + 9'h001, 1'b1);
        fill();
        setsec(s);
        op(fpc_pkg::MODE_WRITE, fpc_pkg::KEY_VALID);
        op(fpc_pkg::MODE_LOCK, fpc_pkg::KEY_VALID);
        op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
        cmp(s, 1'b0);
        $display("test buffer clear and lock done");
        for (int sel = 0; sel < 4; sel++) begin
            case (sel)
                0: top = fpc_pkg::PROT_TOP_00;
                1: top = fpc_pkg::PROT_TOP_01;
                2: top = fpc_pkg::PROT_TOP_10;
                default: top = fpc_pkg::PROT_TOP_11;
            endcase
            s = top[14:6];
            cfg = {1'b1, 2'(sel), 1'b1};
            fill();
            setsec(s);
            op(fpc_pkg::MODE_WRITE, fpc_pkg::KEY_VALID);
            setsec(s + 9'h001);
            op(fpc_pkg::MODE_WRITE, fpc_pkg::KEY_VALID);
            cfg.protect_enable_n = 1'b0;
            op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
            cmp(s + 9'h001, 1'b1);
            setsec(s);
            op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
            cmp(s, 1'b0);
            cfg.protect_enable_n = 1'b1;
            op(fpc_pkg::MODE_ERASE, fpc_pkg::KEY_VALID);
            cmp(s, 1'b1);
        end
        $display("test protection area done");
        results();
    end
endmodule // fpc_flash_ctrl_tb

`default_nettype wire
